//--- bidau_pkg.sv
`default_nettype none
package bidau_pkg;
  // ==========================================================
  // Widths
  localparam int NDIG    = 8;
  localparam int SGL_DIG = 4;
  localparam int NSLOT   = 16;

  // ==========================================================
  // Function codes
  localparam logic [9:0] FC_INC_DBL = 10'h253;  // 595
  localparam logic [9:0] FC_DEC_SGL = 10'h254;  // 596
  localparam logic [9:0] FC_DEC_DBL = 10'h255;  // 597
  localparam logic [9:0] FC_MATH_LO = 10'h190;  // 400
  localparam logic [9:0] FC_MATH_HI = 10'h1B3;  // 435
  localparam logic [9:0] FC_ADD_SGN = 10'h190;  // 400
  localparam logic [9:0] FC_RADIX   = 10'h00A;
  localparam logic [3:0] AS_UNIT_MAX = 4'h7;
  localparam logic [3:0] MD_UNIT_MAX = 4'h5;

  // ==========================================================
  // Digits, ranges, steps
  localparam logic [3:0]  DIG_ZERO     = 4'h0;
  localparam logic [3:0]  DIG_MAX      = 4'h9;
  localparam logic [3:0]  DIG_ONE      = 4'h1;
  localparam logic [15:0] ALL_NINE_SGL = 16'h9999;
  localparam logic signed [31:0] IMM_MIN = 32'shFFFF8000;
  localparam logic signed [31:0] IMM_MAX = 32'sh00007FFF;
  localparam logic signed [15:0] OFS_MIN = 16'shF800;
  localparam logic signed [15:0] OFS_MAX = 16'sh07FF;
  localparam logic [15:0] IR_STEP = 16'h0001;

  // ==========================================================
  // Register port map
  localparam logic [3:0]  REG_CTRL = 4'h0;
  localparam logic [3:0]  REG_STAT = 4'h4;
  localparam logic [3:0]  REG_RES  = 4'h8;
  localparam int          CTRL_EN_BIT = 0;
  localparam logic        CTRL_EN_RST = 1'b1;
  localparam int          STAT_FAULT  = 0;
  localparam int          STAT_EQ     = 1;
  localparam int          STAT_BOR    = 2;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    VAR_LEVEL = 2'b00, VAR_UP = 2'b01, VAR_DOWN = 2'b10, VAR_IMMED = 2'b11
  } bidau_var_t;
  typedef enum logic [1:0] {
    MOP_ADD = 2'b00, MOP_SUB = 2'b01, MOP_MUL = 2'b10, MOP_DIV = 2'b11
  } bidau_mop_t;
  typedef enum logic [1:0] {
    NUM_SGN = 2'b00, NUM_UNS = 2'b01, NUM_BCD = 2'b10
  } bidau_num_t;
  typedef enum logic [2:0] {
    AM_DIRECT = 3'b000, AM_IR = 3'b001, AM_IR_CONST = 3'b010,
    AM_IR_DR = 3'b011, AM_IR_POSTINC = 3'b100, AM_IR_PREDEC = 3'b101
  } bidau_am_t;
  typedef struct packed {
    logic       ok;
    bidau_mop_t mop;
    bidau_num_t num;
    logic       dbl;
    logic       cy;
  } bidau_dec_t;
endpackage
`default_nettype wire

//--- bidau_if.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// BCD step carrier
interface bidau_bcd_if;
  logic [31:0] opnd;
  logic        dbl;
  logic        inc;
  logic [31:0] res;
  logic        valid;
  logic        zero;
  logic        wrap;
  modport calc (input opnd, dbl, inc, output res, valid, zero, wrap);
  modport user (output opnd, dbl, inc, input res, valid, zero, wrap);
endinterface

// ==========================================================
// Operand address carrier
interface bidau_addr_if;
  logic [2:0]  mode;
  logic [15:0] base;
  logic [15:0] ir;
  logic [15:0] dr;
  logic [15:0] ofs;
  logic [15:0] ea;
  logic [15:0] ir_new;
  logic        ir_wr;
  logic        ofs_bad;
  modport gen  (input mode, base, ir, dr, ofs, output ea, ir_new, ir_wr, ofs_bad);
  modport user (output mode, base, ir, dr, ofs, input ea, ir_new, ir_wr, ofs_bad);
endinterface
`default_nettype wire

//--- bidau_bcd_step.sv
`timescale 1ns/1ns
`default_nettype none
module bidau_bcd_step
  import bidau_pkg::*;
(
  bidau_bcd_if.calc b  // Operand in, result out
);
  // ==========================================================
  // Digit ripple
  logic [NDIG:0]   cy;
  logic [NDIG-1:0] bad;
  logic [NDIG-1:0] nz;

  // Digit above nine
  function automatic logic dig_bad(input logic [3:0] d);
    return d > DIG_MAX;
  endfunction

  assign cy[0] = 1'b1;

  // One stage per digit; upper half idle for single word
  for (genvar i = 0; i < NDIG; i++) begin : g_dig
    logic [3:0] d;
    logic       act;
    logic       turn;
    assign d    = b.opnd[i*4 +: 4];
    assign act  = (i < SGL_DIG) || b.dbl;
    assign turn = cy[i] && act && (b.inc ? (d == DIG_MAX) : (d == DIG_ZERO));
    assign cy[i+1] = turn;
    assign b.res[i*4 +: 4] = !(cy[i] && act) ? d :
                             turn ? (b.inc ? DIG_ZERO : DIG_MAX) :
                             b.inc ? d + DIG_ONE : d - DIG_ONE;
    assign bad[i] = act && dig_bad(d);
    assign nz[i]  = act && (b.res[i*4 +: 4] != DIG_ZERO);
  end

  // Status of the step
  assign b.valid = ~|bad;
  assign b.zero  = ~|nz;
  assign b.wrap  = |cy[NDIG:1];
endmodule
`default_nettype wire

//--- bidau_addr_gen.sv
`timescale 1ns/1ns
`default_nettype none
module bidau_addr_gen
  import bidau_pkg::*;
(
  bidau_addr_if.gen a  // Addressing mode in, address out
);
  // ==========================================================
  // Effective address and index update
  always_comb begin
    a.ea      = a.base;
    a.ir_new  = a.ir;
    a.ir_wr   = 1'b0;
    a.ofs_bad = 1'b0;
    case (a.mode)
      AM_DIRECT: begin
        a.ea = a.base;
      end
      AM_IR: begin
        a.ea = a.ir;
      end
      AM_IR_CONST: begin
        a.ofs_bad = ($signed(a.ofs) < OFS_MIN) || ($signed(a.ofs) > OFS_MAX);
        a.ea      = a.ir + a.ofs;
      end
      AM_IR_DR: begin
        a.ea = a.ir + a.dr;
      end
      AM_IR_POSTINC: begin
        a.ea     = a.ir;
        a.ir_new = a.ir + IR_STEP;
        a.ir_wr  = 1'b1;
      end
      AM_IR_PREDEC: begin
        a.ir_new = a.ir - IR_STEP;
        a.ea     = a.ir - IR_STEP;
        a.ir_wr  = 1'b1;
      end
      default: begin
        a.ofs_bad = 1'b1;
      end
    endcase
  end
endmodule
`default_nettype wire

//--- bidau_unit.sv
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Single-word BCD decrement writes back same word
// - Level variant repeats while condition held
// - Rising variant runs once per edge
// - Falling-edge and immediate refresh unsupported
// - Single-word equals flag when result 0000
// - Single-word borrow when digit 0 to 9
// - Non-BCD single word raises fault flag
// - Double-word decrement over upper and lower word
// - Double decrement level repeats, rising runs once
// - Double equals flag when result all zero
// - Double borrow when any digit 0 to 9
// - Non-BCD double word raises fault flag
// - Double-word BCD increment, level or rising
// - Decode math codes 400 to 435
// - Signed add immediates 16-bit, result not constant
// - Index addressing with offset range checks
module bidau_unit
  import bidau_pkg::*;
(
  input  wire logic        ref_clk_in,          // 10 MHz clock
  input  wire logic        reset_in,            // Sync reset, high
  input  wire logic        clk_en_in,           // Freezes state when low
  input  wire logic [3:0]  reg_addr_in,         // Register byte address
  input  wire logic [31:0] reg_wdata_in,        // Register write data
  input  wire logic        reg_wr_in,           // Register write strobe
  input  wire logic        reg_rd_in,           // Register read strobe
  output logic      [31:0] reg_rdata_out,       // Read data, next cycle
  input  wire logic        req_valid_in,        // Instruction offered
  input  wire logic [9:0]  func_code_in,        // Function code, binary
  input  wire logic [1:0]  variant_in,          // Execution variant
  input  wire logic        cond_in,             // Execution condition
  input  wire logic [3:0]  slot_in,             // Instruction slot id
  input  wire logic [15:0] target_word_in,      // Addressed word
  input  wire logic [15:0] target_word_hi_in,   // Next-higher word
  input  wire logic [2:0]  am_mode_in,          // Addressing mode
  input  wire logic [15:0] base_addr_in,        // Direct address
  input  wire logic [15:0] index_pointer_in,    // Index pointer value
  input  wire logic [15:0] offset_register_in,  // Offset register value
  input  wire logic [15:0] const_offset_in,     // Signed constant offset
  input  wire logic [1:0]  src_imm_in,          // Sources are constants
  input  wire logic        res_imm_in,          // Result is a constant
  input  wire logic [31:0] imm_a_in,            // First source constant
  input  wire logic [31:0] imm_b_in,            // Second source constant
  output logic             wr_en_out,           // Write-back pulse
  output logic             wr_dbl_out,          // Write both words
  output logic      [15:0] wr_addr_out,         // Lower word address
  output logic      [31:0] wr_data_out,         // Upper and lower word
  output logic             ir_wr_out,           // Index write pulse
  output logic      [15:0] ir_data_out,         // New index value
  output logic             fault_flag_out,      // Error flag
  output logic             equals_flag_out,     // Equals flag
  output logic             borrow_flag_out,     // Carry flag
  output logic             math_valid_out,      // Math decode pulse
  output logic      [1:0]  math_op_out,         // Add, sub, mul, div
  output logic      [1:0]  math_num_out,        // Signed, unsigned, BCD
  output logic             math_dbl_out,        // Double-word form
  output logic             math_cy_out          // With-carry form
);
  // ==========================================================
  // Submodules
  bidau_bcd_if  bcd ();
  bidau_addr_if adr ();

  bidau_bcd_step u_bcd (
    .b (bcd.calc)
  );

  bidau_addr_gen u_adr (
    .a (adr.gen)
  );

  // ==========================================================
  // Decode helpers
  function automatic logic is_bcd_code(input logic [9:0] fc);
    return (fc == FC_INC_DBL) || (fc == FC_DEC_SGL) || (fc == FC_DEC_DBL);
  endfunction

  function automatic logic imm_out(input logic [31:0] v);
    return ($signed(v) < IMM_MIN) || ($signed(v) > IMM_MAX);
  endfunction

  function automatic bidau_dec_t math_dec(input logic [9:0] fc);
    bidau_dec_t d;
    logic [9:0] diff;
    logic [9:0] tens;
    logic [3:0] unit;
    d    = '0;
    diff = fc - FC_MATH_LO;
    tens = diff / FC_RADIX;
    unit = 4'(diff % FC_RADIX);
    d.mop = bidau_mop_t'(tens[1:0]);
    d.dbl = unit[0];
    if ((fc >= FC_MATH_LO) && (fc <= FC_MATH_HI)) begin
      if (tens[1] == 1'b0) begin
        d.ok  = (unit <= AS_UNIT_MAX);
        d.num = unit[2] ? NUM_BCD : NUM_SGN;
        d.cy  = unit[1];
      end else begin
        d.ok  = (unit <= MD_UNIT_MAX);
        d.num = unit[2] ? NUM_BCD : (unit[1] ? NUM_UNS : NUM_SGN);
      end
    end
    return d;
  endfunction

  // ==========================================================
  // State
  logic             ctrl_en_r;
  logic [NSLOT-1:0] prev_cond_r;
  logic             fault_r;
  logic             equals_r;
  logic             borrow_r;
  logic             wr_en_r;
  logic             wr_dbl_r;
  logic [15:0]      wr_addr_r;
  logic [31:0]      wr_data_r;
  logic             ir_wr_r;
  logic [15:0]      ir_data_r;
  logic             math_valid_r;
  bidau_dec_t       math_r;
  logic [31:0]      rdata_r;
  logic [31:0]      rdata_nxt;

  // ==========================================================
  // Request qualification
  bidau_dec_t dec;
  logic       taken;
  logic       var_ok;
  logic       fire;
  logic       bcd_req;
  logic       go;
  logic       good;
  logic       math_go;
  logic       var_bad;
  logic       imm_bad;

  assign dec     = math_dec(func_code_in);
  assign taken   = clk_en_in && req_valid_in && ctrl_en_r;
  assign var_ok  = (variant_in == VAR_LEVEL) || (variant_in == VAR_UP);
  // Level every cycle, rising on off-to-on
  assign fire    = (variant_in == VAR_UP) ? (cond_in && !prev_cond_r[slot_in])
                                          : cond_in;
  assign bcd_req = taken && is_bcd_code(func_code_in);
  assign go      = bcd_req && var_ok && fire;
  assign good    = bcd.valid && !adr.ofs_bad;
  assign math_go = taken && dec.ok && var_ok && fire;
  assign var_bad = taken && (is_bcd_code(func_code_in) || dec.ok) && !var_ok;
  // Signed add constant range
  assign imm_bad = (func_code_in == FC_ADD_SGN) &&
                   (res_imm_in || (src_imm_in[0] && imm_out(imm_a_in)) ||
                    (src_imm_in[1] && imm_out(imm_b_in)));

  // Operands to the BCD step
  assign bcd.opnd = {target_word_hi_in, target_word_in};
  assign bcd.dbl  = (func_code_in != FC_DEC_SGL);
  assign bcd.inc  = (func_code_in == FC_INC_DBL);

  // Operands to the address generator
  assign adr.mode = am_mode_in;
  assign adr.base = base_addr_in;
  assign adr.ir   = index_pointer_in;
  assign adr.dr   = offset_register_in;
  assign adr.ofs  = const_offset_in;

  // ==========================================================
  // Control register
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ctrl_en_r <= CTRL_EN_RST;
    end else if (clk_en_in && reg_wr_in && (reg_addr_in == REG_CTRL)) begin
      ctrl_en_r <= reg_wdata_in[CTRL_EN_BIT];
    end
  end

  // Last condition per slot for edge detection
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      prev_cond_r <= '0;
    end else if (taken) begin
      prev_cond_r[slot_in] <= cond_in;
    end
  end

  // ==========================================================
  // Condition flags
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      fault_r  <= 1'b0;
      equals_r <= 1'b0;
      borrow_r <= 1'b0;
    end else if (clk_en_in) begin
      if (go) begin
        fault_r <= !good;
        if (good) begin
          equals_r <= bcd.zero;
          borrow_r <= bcd.wrap;
        end
      end else if (math_go) begin
        fault_r <= imm_bad || adr.ofs_bad;
      end else if (var_bad) begin
        fault_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Write-back of the result
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      wr_en_r   <= 1'b0;
      wr_dbl_r  <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= '0;
    end else if (clk_en_in) begin
      wr_en_r <= go && good;
      if (go && good) begin
        wr_dbl_r  <= bcd.dbl;
        wr_addr_r <= adr.ea;
        wr_data_r <= bcd.res;
      end
    end
  end

  // Index pointer update
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ir_wr_r   <= 1'b0;
      ir_data_r <= '0;
    end else if (clk_en_in) begin
      ir_wr_r <= (go || math_go) && adr.ir_wr && !adr.ofs_bad;
      if ((go || math_go) && adr.ir_wr) begin
        ir_data_r <= adr.ir_new;
      end
    end
  end

  // Math decode result
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      math_valid_r <= 1'b0;
      math_r       <= '0;
    end else if (clk_en_in) begin
      math_valid_r <= math_go && !imm_bad && !adr.ofs_bad;
      if (math_go) begin
        math_r <= dec;
      end
    end
  end

  // ==========================================================
  // Register read port
  always_comb begin
    rdata_nxt = '0;
    case (reg_addr_in)
      REG_CTRL: rdata_nxt[CTRL_EN_BIT] = ctrl_en_r;
      REG_STAT: begin
        rdata_nxt[STAT_FAULT] = fault_r;
        rdata_nxt[STAT_EQ]    = equals_r;
        rdata_nxt[STAT_BOR]   = borrow_r;
      end
      REG_RES:  rdata_nxt = wr_data_r;
      default:  rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rdata_r <= '0;
    end else if (clk_en_in) begin
      rdata_r <= reg_rd_in ? rdata_nxt : '0;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata_out   = rdata_r;
  assign wr_en_out       = wr_en_r;
  assign wr_dbl_out      = wr_dbl_r;
  assign wr_addr_out     = wr_addr_r;
  assign wr_data_out     = wr_data_r;
  assign ir_wr_out       = ir_wr_r;
  assign ir_data_out     = ir_data_r;
  assign fault_flag_out  = fault_r;
  assign equals_flag_out = equals_r;
  assign borrow_flag_out = borrow_r;
  assign math_valid_out  = math_valid_r;
  assign math_op_out     = math_r.mop;
  assign math_num_out    = math_r.num;
  assign math_dbl_out    = math_r.dbl;
  assign math_cy_out     = math_r.cy;

  // ==========================================================
  // Checks
  default clocking chk_cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  AST_SGL_WRITE: assert property (
    go && good && (func_code_in == FC_DEC_SGL) |=>
      wr_en_out && !wr_dbl_out && (wr_data_out[15:0] == $past(bcd.res[15:0])))
    else $error("single decrement not written back");

  AST_LEVEL_REPEAT: assert property (
    taken && (variant_in == VAR_LEVEL) && cond_in && bcd_req && good |=> wr_en_out)
    else $error("level variant did not execute");

  AST_EDGE_ONCE: assert property (
    taken && (variant_in == VAR_UP) && prev_cond_r[slot_in] |=> !wr_en_out)
    else $error("rising variant executed without an edge");

  AST_NO_FALL: assert property (
    bcd_req && !var_ok |=> fault_flag_out && !wr_en_out)
    else $error("unsupported variant accepted");

  AST_EQ_SGL: assert property (
    $rose(wr_en_out) && !wr_dbl_out |-> equals_flag_out == (wr_data_out[15:0] == '0))
    else $error("equals flag wrong after single decrement");

  AST_ZERO_WRAP: assert property (
    go && good && (func_code_in == FC_DEC_SGL) && (target_word_in == '0) |=>
      borrow_flag_out && !equals_flag_out && (wr_data_out[15:0] == ALL_NINE_SGL))
    else $error("zero decrement did not wrap to nines");

  AST_FAULT_NOTBCD: assert property (
    go && !bcd.valid |=> fault_flag_out && !wr_en_out)
    else $error("non-BCD operand not faulted");

  AST_EQ_DBL: assert property (
    $rose(wr_en_out) && wr_dbl_out |-> equals_flag_out == (wr_data_out == '0))
    else $error("equals flag wrong after double operation");

  AST_IMM_RESULT: assert property (
    math_go && (func_code_in == FC_ADD_SGN) && res_imm_in |=>
      fault_flag_out && !math_valid_out)
    else $error("constant result operand accepted");
endmodule
`default_nettype wire

//--- bidau_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module bidau_mem_model
  import bidau_pkg::*;
(
  input  wire logic        clk_in,      // CPU clock
  input  wire logic        wr_en_in,    // Write-back pulse
  input  wire logic        wr_dbl_in,   // Write upper word too
  input  wire logic [15:0] wr_addr_in,  // Lower word address
  input  wire logic [31:0] wr_data_in,  // Upper and lower word
  input  wire logic [15:0] rd_addr_in,  // Addressed word
  output logic      [15:0] lo_out,      // Addressed word content
  output logic      [15:0] hi_out       // Next-higher word content
);
  logic [15:0] mem_r [NSLOT];

  // ==========================================================
  // Operand memory, small window of words
  initial begin
    for (int i = 0; i < NSLOT; i++) begin
      mem_r[i] = 16'h0050;
    end
  end

  // Upper half sits at the next-higher word
  assign lo_out = mem_r[rd_addr_in[3:0]];
  assign hi_out = mem_r[rd_addr_in[3:0] + 4'h1];

  // Write-back lands one edge after the pulse
  always @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_r[wr_addr_in[3:0]] <= wr_data_in[15:0];
      if (wr_dbl_in) begin
        mem_r[wr_addr_in[3:0] + 4'h1] <= wr_data_in[31:16];
      end
    end
  end

  // Preload between instructions
  task automatic load(input logic [3:0] a, input logic [15:0] v);
    mem_r[a] = v;
  endtask
endmodule
`default_nettype wire

//--- bidau_unit_tb.sv
`timescale 1ns/1ns
`default_nettype none
module bidau_unit_tb
  import bidau_pkg::*;
();
  logic        ref_clk_in, reset_in, clk_en_in, reg_wr_in, reg_rd_in, req_valid_in;
  logic        cond_in, res_imm_in, wr_en_out, wr_dbl_out, ir_wr_out, fault_flag_out;
  logic        equals_flag_out, borrow_flag_out, math_valid_out, math_dbl_out, math_cy_out;
  logic [1:0]  variant_in, src_imm_in, math_op_out, math_num_out;
  logic [2:0]  am_mode_in, flg;
  logic [3:0]  reg_addr_in, slot_in;
  logic [9:0]  func_code_in;
  logic [15:0] target_word_in, target_word_hi_in, base_addr_in, index_pointer_in, rd_addr;
  logic [15:0] offset_register_in, const_offset_in, wr_addr_out, ir_data_out;
  logic [31:0] reg_wdata_in, imm_a_in, imm_b_in, reg_rdata_out, wr_data_out;
  int          n_fail, checks, cyc;

  assign flg = {borrow_flag_out, equals_flag_out, fault_flag_out};

  bidau_unit bidau_unit_inst (
    .ref_clk_in, .reset_in, .clk_en_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .req_valid_in, .func_code_in, .variant_in, .cond_in,
    .slot_in, .target_word_in, .target_word_hi_in, .am_mode_in, .base_addr_in,
    .index_pointer_in, .offset_register_in, .const_offset_in, .src_imm_in,
    .res_imm_in, .imm_a_in, .imm_b_in, .wr_en_out, .wr_dbl_out, .wr_addr_out,
    .wr_data_out, .ir_wr_out, .ir_data_out, .fault_flag_out, .equals_flag_out,
    .borrow_flag_out, .math_valid_out, .math_op_out, .math_num_out, .math_dbl_out,
    .math_cy_out
  );
  bidau_mem_model bidau_mem_model_inst (
    .clk_in(ref_clk_in), .wr_en_in(wr_en_out), .wr_dbl_in(wr_dbl_out),
    .wr_addr_in(wr_addr_out), .wr_data_in(wr_data_out), .rd_addr_in(rd_addr),
    .lo_out(target_word_in), .hi_out(target_word_hi_in)
  );

  // ==========================================================
  // Clock and hang guard
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      complete_run();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One instruction step
  task automatic run(input logic [9:0] fc, input logic [1:0] vr, input logic cd,
                     input logic [3:0] sl, input logic [15:0] ad);
    @(posedge ref_clk_in);
    req_valid_in <= 1'b1;
    func_code_in <= fc;
    variant_in <= vr;
    cond_in <= cd;
    slot_in <= sl;
    base_addr_in <= ad;
    rd_addr <= ad;
    @(posedge ref_clk_in);
    req_valid_in <= 1'b0;
    #1;
  endtask
  // Preload after write-back lands
  task automatic ld(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk_in);
    #1;
    bidau_mem_model_inst.load(a, v);
  endtask
  // Register write or read
  task automatic reg_acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    reg_wr_in <= w;
    reg_rd_in <= !w;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    #1;
    if (!w) chk(reg_rdata_out, d);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_sgl();
    ld(4'h2, 16'h0001);
    run(FC_DEC_SGL, 2'h0, 1'b1, 4'h0, 16'h0002);
    chk({wr_en_out, wr_dbl_out, wr_addr_out, wr_data_out[15:0]}, 34'h200020000);
    chk(flg, 3'h2);
    run(FC_DEC_SGL, 2'h0, 1'b1, 4'h0, 16'h0002);
    chk({wr_data_out[15:0], flg}, {16'h9999, 3'h4});
    reg_acc(1'b0, REG_STAT, 32'h00000004);
    chk(bidau_mem_model_inst.mem_r[2], 16'h9999);
    ld(4'h3, 16'h0010);
    run(FC_DEC_SGL, 2'h0, 1'b1, 4'h0, 16'h0003);
    chk({wr_data_out[15:0], flg}, {16'h0009, 3'h4});
    ld(4'h3, 16'h0012);
    run(FC_DEC_SGL, 2'h0, 1'b1, 4'h0, 16'h0003);
    chk({wr_data_out[15:0], flg}, {16'h0011, 3'h0});
  endtask
  task automatic t_rise();
    run(FC_DEC_SGL, 2'h1, 1'b0, 4'h5, 16'h0004);
    chk(wr_en_out, 1'b0);
    run(FC_DEC_SGL, 2'h1, 1'b1, 4'h5, 16'h0004);
    chk({wr_en_out, wr_data_out[15:0]}, {1'b1, 16'h0049});
    run(FC_DEC_SGL, 2'h1, 1'b1, 4'h5, 16'h0004);
    chk(wr_en_out, 1'b0);
  endtask
  task automatic t_fault();
    ld(4'h5, 16'h12A4);
    run(FC_DEC_SGL, 2'h0, 1'b1, 4'h0, 16'h0005);
    chk({wr_en_out, fault_flag_out}, 2'h1);
    ld(4'h5, 16'h0100);
    run(FC_DEC_SGL, 2'h0, 1'b1, 4'h0, 16'h0005);
    chk({wr_data_out[15:0], flg}, {16'h0099, 3'h4});
  endtask
  task automatic t_dbl();
    ld(4'h6, 16'h0000);
    ld(4'h7, 16'h0001);
    run(FC_DEC_DBL, 2'h0, 1'b1, 4'h0, 16'h0006);
    chk({wr_en_out, wr_dbl_out, wr_data_out, flg}, {2'h3, 32'h00009999, 3'h4});
    ld(4'h6, 16'h0001);
    ld(4'h7, 16'h0000);
    run(FC_DEC_DBL, 2'h0, 1'b1, 4'h0, 16'h0006);
    chk({wr_data_out, flg}, {32'h00000000, 3'h2});
    run(FC_DEC_DBL, 2'h0, 1'b1, 4'h0, 16'h0006);
    chk({wr_data_out, flg}, {32'h99999999, 3'h4});
    ld(4'h7, 16'h00B0);
    run(FC_DEC_DBL, 2'h0, 1'b1, 4'h0, 16'h0006);
    chk({wr_en_out, fault_flag_out}, 2'h1);
    ld(4'h7, 16'h0001);
    run(FC_DEC_DBL, 2'h1, 1'b1, 4'h6, 16'h0006);
    chk(wr_en_out, 1'b1);
    run(FC_DEC_DBL, 2'h1, 1'b1, 4'h6, 16'h0006);
    chk(wr_en_out, 1'b0);
  endtask
  task automatic t_inc();
    ld(4'h8, 16'h9999);
    ld(4'h9, 16'h0000);
    run(FC_INC_DBL, 2'h1, 1'b0, 4'h7, 16'h0008);
    chk(wr_en_out, 1'b0);
    run(FC_INC_DBL, 2'h1, 1'b1, 4'h7, 16'h0008);
    chk({wr_en_out, wr_dbl_out, wr_data_out, fault_flag_out}, {2'h3, 32'h00010000, 1'b0});
    run(FC_INC_DBL, 2'h0, 1'b1, 4'h7, 16'h0008);
    chk(wr_data_out, 32'h00010001);
  endtask
  task automatic t_var();
    for (int v = 2; v < 4; v++) begin
      run(FC_DEC_SGL, 2'(v), 1'b1, 4'h0, 16'h000A);
      chk({wr_en_out, fault_flag_out}, 2'h1);
      run(FC_DEC_SGL, 2'h0, 1'b1, 4'h0, 16'h000A);
      chk({wr_en_out, fault_flag_out}, 2'h2);
    end
    reg_acc(1'b1, REG_CTRL, 32'h00000000);
    run(FC_DEC_SGL, 2'h0, 1'b1, 4'h0, 16'h000B);
    chk(wr_en_out, 1'b0);
    reg_acc(1'b1, REG_CTRL, 32'h00000001);
  endtask
  task automatic t_math();
    logic [1:0] en;
    for (int t = 0; t < 4; t++) begin
      for (int u = 0; u < 8; u++) begin
        if (t < 2 || u < 6) begin
          run(FC_MATH_LO + FC_RADIX * 10'(t) + 10'(u), 2'h0, 1'b1, 4'h0, 16'h0000);
          en = (t < 2) ? {u[2], 1'b0} : 2'(u / 2);
          chk({math_valid_out, math_op_out, math_num_out, math_dbl_out, math_cy_out},
              {1'b1, 2'(t), en, 1'(u % 2), 1'((t < 2) && u[1])});
        end
      end
    end
  endtask
  task automatic imm(input logic [1:0] s, input logic r, input logic [31:0] a,
                     input logic [31:0] b, input logic ok);
    @(posedge ref_clk_in);
    src_imm_in <= s;
    res_imm_in <= r;
    imm_a_in <= a;
    imm_b_in <= b;
    run(FC_ADD_SGN, 2'h0, 1'b1, 4'h0, 16'h0000);
    chk({math_valid_out, fault_flag_out}, {ok, !ok});
  endtask
  task automatic am(input logic [2:0] m, input logic [15:0] k, input logic [15:0] ea,
                    input logic ok, input logic [16:0] irw);
    @(posedge ref_clk_in);
    am_mode_in <= m;
    const_offset_in <= k;
    run(FC_DEC_SGL, 2'h0, 1'b1, 4'h0, ea);
    chk({wr_en_out, fault_flag_out}, {ok, !ok});
    if (ok) chk({wr_addr_out, ir_wr_out}, {ea, irw[16]});
    if (irw[16]) chk(ir_data_out, irw[15:0]);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {reset_in, clk_en_in} = 2'h3;
    {reg_wr_in, reg_rd_in, req_valid_in, cond_in, res_imm_in} = 5'h00;
    {variant_in, src_imm_in, am_mode_in, reg_addr_in, slot_in, func_code_in} = 25'h0;
    {index_pointer_in, base_addr_in, rd_addr, offset_register_in, const_offset_in} = 80'h00100000000000030000;
    {reg_wdata_in, imm_a_in, imm_b_in} = 96'h0;
    {n_fail, checks, cyc} = 96'h0;
    repeat (6) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    #1;
    chk({flg, wr_en_out, math_valid_out}, 5'h00);
    reg_acc(1'b0, REG_CTRL, 32'h00000001);
    reg_acc(1'b0, 4'hC, 32'h00000000);
    t_sgl();
    t_rise();
    t_fault();
    t_dbl();
    t_inc();
    t_var();
    t_math();
    imm(2'h1, 1'b0, IMM_MAX, 32'h0, 1'b1);
    imm(2'h1, 1'b0, 32'h00008000, 32'h0, 1'b0);
    imm(2'h2, 1'b0, 32'h0, IMM_MIN, 1'b1);
    imm(2'h2, 1'b0, 32'h0, 32'hFFFF7FFF, 1'b0);
    imm(2'h0, 1'b1, 32'h0, 32'h0, 1'b0);
    am(3'h2, 16'h07FF, 16'h080F, 1'b1, 17'h0);
    am(3'h2, 16'h0800, 16'h0000, 1'b0, 17'h0);
    am(3'h2, 16'hF800, 16'hF810, 1'b1, 17'h0);
    am(3'h2, 16'hF7FF, 16'h0000, 1'b0, 17'h0);
    am(3'h3, 16'h0000, 16'h0013, 1'b1, 17'h0);
    am(3'h4, 16'h0000, 16'h0010, 1'b1, 17'h10011);
    am(3'h5, 16'h0000, 16'h000F, 1'b1, 17'h1000F);
    complete_run();
  end
endmodule
`default_nettype wire
